// file: hdl/adcss_pkg.sv
// Purpose: Shared constants for the eight-input converter scan sequencer.
// Assumes: One 100 MHz clock; a machine cycle is a fixed count of clocks.
// Notes: Register offsets are byte addresses of aligned 32-bit words.
package adcss_pkg;

    // Clock rate and machine cycle length.
    localparam int unsigned CLK_MHZ = 100;
    localparam int unsigned MC_DIV = 12;
    localparam logic [3:0] MC_LAST = 4'(MC_DIV - 1);

    // Successive approximation: 256 ladder steps, one sample cycle.
    localparam int unsigned LADDER_STEPS = 256;
    localparam int unsigned RES_BITS = $clog2(LADDER_STEPS);
    localparam logic [3:0] SAR_LAST_STEP = 4'(RES_BITS);
    localparam logic [7:0] SAR_FIRST_TRIAL = 8'h80;
    localparam int unsigned CONV_MC = RES_BITS + 2;

    // Channel count and slot numbers.
    localparam logic [2:0] LAST_SLOT = 3'h7;
    localparam logic [2:0] FIRST_UPPER_SLOT = 3'h4;

    // Register byte offsets.
    localparam logic [7:0] OFS_CONTROL = 8'h00;
    localparam logic [7:0] OFS_THRESH = 8'h04;
    localparam logic [7:0] OFS_RESULT0 = 8'h08;
    localparam logic [7:0] OFS_RESULT7 = 8'h24;

    // Control register bit positions.
    localparam int unsigned BIT_DONE = 0;
    localparam int unsigned BIT_ENABLE = 1;
    localparam int unsigned BIT_SEL0 = 2;
    localparam int unsigned BIT_SEL1 = 3;
    localparam int unsigned BIT_MODE = 4;
    localparam int unsigned BIT_TRIG = 5;
    localparam int unsigned BIT_IRQEN = 6;
    localparam int unsigned BIT_BUSY = 8;

    // Values after reset.
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [31:0] RST_WORD = 32'h0000_0000;

endpackage : adcss_pkg

// file: hdl/adcss_sync.sv
// Purpose: Two-flop synchroniser for pins from outside the clock domain.
// Assumes: Each bit is an independent level.
// Notes: Only the second flop is visible outside.
module adcss_sync #(
    parameter int unsigned WIDTH = 1
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] meta_r;

    // First flop feeds only the second.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            meta_r <= '0;
            sync_out <= '0;
        end else begin
            meta_r <= async_in;
            sync_out <= meta_r;
        end
    end

endmodule : adcss_sync

// file: hdl/adcss_sar.sv
// Purpose: Successive approximation engine for one conversion.
// Assumes: cmp_above is high while the held input exceeds ladder_code.
// Notes: One sample machine cycle, then one machine cycle per result bit.
module adcss_sar (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic mc_tick,
    input wire logic start,
    input wire logic abort,
    input wire logic cmp_above,
    output logic [7:0] ladder_code,
    output logic sample_hold,
    output logic busy,
    output logic done,
    output logic [7:0] result
);

    logic [3:0] step_r;
    logic [2:0] bit_idx;

    assign bit_idx = 3'(adcss_pkg::SAR_LAST_STEP - step_r);

    // Sample, then decide one bit per machine cycle from the top.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            step_r <= 4'h0;
            ladder_code <= adcss_pkg::RST_BYTE;
            sample_hold <= 1'b0;
            busy <= 1'b0;
            done <= 1'b0;
            result <= adcss_pkg::RST_BYTE;
        end else begin
            done <= 1'b0;
            if (abort) begin
                busy <= 1'b0;
                sample_hold <= 1'b0;
            end else if (mc_tick && start) begin
                busy <= 1'b1;
                sample_hold <= 1'b1;
                step_r <= 4'h0;
                ladder_code <= adcss_pkg::SAR_FIRST_TRIAL;
            end else if (mc_tick && busy) begin
                sample_hold <= 1'b0;
                step_r <= step_r + 4'h1;
                if (step_r != 4'h0) begin
                    ladder_code[bit_idx] <= cmp_above;
                    if (bit_idx != 3'h0) begin
                        ladder_code[bit_idx - 3'h1] <= 1'b1;
                    end
                end
                if (step_r == adcss_pkg::SAR_LAST_STEP) begin
                    busy <= 1'b0;
                    done <= 1'b1;
                    result <= {ladder_code[7:1], cmp_above};
                end
            end
        end
    end

endmodule : adcss_sar

// file: hdl/adcss_top.sv
// Purpose: Scan sequencer, result registers and AHB-Lite slave of the converter.
// Assumes: Analog comparators sit outside and report as asynchronous levels.
// Notes: Zero wait state slave; every response is OKAY.
//
// Notes on behaviour
// - Each result is an 8-bit successive approximation.
// - Result register written when its conversion ends.
// - Channel 0 compare bit is the MSB.
// - Compare bit set when input exceeds reference.
// - Compare bits update per channel, both modes.
// - Trigger-mode bit picks internal or external start.
// - Internal start on the next machine cycle.
// - Done flag after channel 7, gated interrupt.
// - Internal mode restarts at once, overwriting results.
// - Clearing enable halts all conversion.
// - Trigger pin sampled per cycle, high-then-low edge.
// - External edge runs one cycle then idles.
// - Edges during a running cycle are ignored.
// - Scan mode converts inputs 0 to 7.
// - Select mode converts chosen input four times.
// - Two select bits choose input 0 to 3.
// - Both modes always perform eight conversions.
//
// The implementer's own choices: the AHB-Lite interface to the registers and the register offsets.
module adcss_top (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic external_trigger_pin,
    input wire logic ladder_compare_in,
    input wire logic threshold_compare_in,
    output logic [2:0] mux_channel,
    output logic [7:0] ladder_code,
    output logic sample_hold,
    output logic converter_irq
);

    typedef enum logic [0:0] {
        ADCSS_IDLE,
        ADCSS_RUN
    } adcss_state_t;

    ////////////////////////////////////////////////////////////////////////////
    // Declarations
    ////////////////////////////////////////////////////////////////////////////

    logic [3:0] mc_cnt_r;
    logic mc_tick_r;
    logic [2:0] pins_sync;
    logic trig_sync;
    logic ladder_above;
    logic thresh_above;
    logic trig_prev_r;
    logic trig_fall;
    adcss_state_t state_r;
    logic [2:0] slot_r;
    logic launch_pend_r;
    logic launch;
    logic [2:0] next_chan;
    logic [2:0] slot_nxt;
    logic sar_busy;
    logic sar_done;
    logic [7:0] sar_result;
    logic [7:0] result_r [8];
    logic [7:0] threshold_compare_result_r;
    logic conversion_done_flag_r;
    logic conversion_enable_bit_r;
    logic select_channel_bit0_r;
    logic select_channel_bit1_r;
    logic input_mode_bit_r;
    logic trigger_mode_bit_r;
    logic irq_enable_r;
    logic addr_valid;
    logic wr_pend_r;
    logic [7:0] wr_addr_r;
    logic ctrl_write;
    logic done_clear;
    logic cycle_end;
    logic [31:0] rd_word;
    logic [7:0] rd_ofs;

    ////////////////////////////////////////////////////////////////////////////
    // Machine cycle divider and pin synchronisers
    ////////////////////////////////////////////////////////////////////////////

    // One-clock tick per machine cycle.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            mc_cnt_r <= 4'h0;
            mc_tick_r <= 1'b0;
        end else begin
            mc_tick_r <= (mc_cnt_r == adcss_pkg::MC_LAST);
            if (mc_cnt_r == adcss_pkg::MC_LAST) begin
                mc_cnt_r <= 4'h0;
            end else begin
                mc_cnt_r <= mc_cnt_r + 4'h1;
            end
        end
    end

    // All three pins come from outside the clock domain.
    adcss_sync #(
        .WIDTH(3)
    ) u_sync (
        .hclk(hclk),
        .hresetn(hresetn),
        .async_in({external_trigger_pin, ladder_compare_in, threshold_compare_in}),
        .sync_out(pins_sync)
    );

    assign trig_sync = pins_sync[2];
    assign ladder_above = pins_sync[1];
    assign thresh_above = pins_sync[0];

    // sample per cycle.
    // The trigger is looked at once per machine cycle; high then low is an edge.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            trig_prev_r <= 1'b0;
        end else if (mc_tick_r) begin
            trig_prev_r <= trig_sync;
        end
    end

    // relies on held levels.
    // A pulse shorter than one machine cycle may fall between samples.
    assign trig_fall = mc_tick_r && trig_prev_r && !trig_sync;

    ////////////////////////////////////////////////////////////////////////////
    // Channel selection
    ////////////////////////////////////////////////////////////////////////////

    // select mode slots.
    // Slots 0 to 3 use the chosen input in select mode, others their own.
    function automatic logic [2:0] slot_channel(input logic [2:0] slot);
        logic [2:0] chan;
        chan = slot;
        if (input_mode_bit_r && (slot < adcss_pkg::FIRST_UPPER_SLOT)) begin
            chan = {1'b0, select_channel_bit1_r, select_channel_bit0_r};
        end
        return chan;
    endfunction : slot_channel

    // scan order 0-7.
    // Slots always count up; scan mode maps slot n to input n.
    assign slot_nxt = (slot_r == adcss_pkg::LAST_SLOT) ? 3'h0 : slot_r + 3'h1;
    assign next_chan = slot_channel(slot_nxt);

    ////////////////////////////////////////////////////////////////////////////
    // Sequencer
    ////////////////////////////////////////////////////////////////////////////

    // next-cycle internal start.
    // A conversion is launched on a machine-cycle tick.
    assign launch = mc_tick_r && conversion_enable_bit_r && (
        ((state_r == ADCSS_IDLE) && !trigger_mode_bit_r) ||
        ((state_r == ADCSS_RUN) && launch_pend_r));

    assign cycle_end = sar_done && (slot_r == adcss_pkg::LAST_SLOT);

    // eight slots always.
    // Each cycle walks all eight slots, whatever the input mode.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_r <= ADCSS_IDLE;
            slot_r <= 3'h0;
            launch_pend_r <= 1'b0;
        end else if (!conversion_enable_bit_r) begin
            state_r <= ADCSS_IDLE;
            slot_r <= 3'h0;
            launch_pend_r <= 1'b0;
        end else begin
            case (state_r)
                ADCSS_IDLE: begin
                    if (launch) begin
                        state_r <= ADCSS_RUN;
                        slot_r <= 3'h0;
                    end else if (trigger_mode_bit_r && trig_fall) begin
                        state_r <= ADCSS_RUN;
                        slot_r <= 3'h0;
                        launch_pend_r <= 1'b1;
                    end
                end
                ADCSS_RUN: begin
                    if (launch) begin
                        launch_pend_r <= 1'b0;
                    end else if (sar_done) begin
                        slot_r <= slot_nxt;
                        if (!cycle_end || !trigger_mode_bit_r) begin
                            launch_pend_r <= 1'b1;
                        end else begin
                            state_r <= ADCSS_IDLE;
                        end
                    end
                end
                default: begin
                    state_r <= ADCSS_IDLE;
                end
            endcase
        end
    end

    // Multiplexer address is set ahead of each launch.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            mux_channel <= 3'h0;
        end else if (state_r == ADCSS_IDLE || !conversion_enable_bit_r) begin
            mux_channel <= slot_channel(3'h0);
        end else if (sar_done) begin
            mux_channel <= next_chan;
        end
    end

    adcss_sar u_sar (
        .hclk(hclk),
        .hresetn(hresetn),
        .mc_tick(mc_tick_r),
        .start(launch),
        .abort(!conversion_enable_bit_r),
        .cmp_above(ladder_above),
        .ladder_code(ladder_code),
        .sample_hold(sample_hold),
        .busy(sar_busy),
        .done(sar_done),
        .result(sar_result)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Results and threshold bits
    ////////////////////////////////////////////////////////////////////////////

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            for (int i = 0; i < 8; i++) begin
                result_r[i] <= adcss_pkg::RST_BYTE;
            end
        end else if (sar_done) begin
            result_r[slot_r] <= sar_result;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            threshold_compare_result_r <= adcss_pkg::RST_BYTE;
        end else if (sar_done) begin
            threshold_compare_result_r[3'h7 - slot_r] <= thresh_above;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // AHB-Lite slave
    ////////////////////////////////////////////////////////////////////////////

    assign addr_valid = hsel && htrans[1] && hready;
    assign ctrl_write = wr_pend_r && (wr_addr_r == adcss_pkg::OFS_CONTROL);
    assign done_clear = ctrl_write && !hwdata[adcss_pkg::BIT_DONE];
    assign rd_ofs = haddr[7:0];

    // Address phase capture for writes.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_r <= 1'b0;
            wr_addr_r <= 8'h00;
        end else begin
            wr_pend_r <= addr_valid && hwrite;
            if (addr_valid) begin
                wr_addr_r <= haddr[7:0];
            end
        end
    end

    // Control bits written in the data phase.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            conversion_enable_bit_r <= 1'b0;
            select_channel_bit0_r <= 1'b0;
            select_channel_bit1_r <= 1'b0;
            input_mode_bit_r <= 1'b0;
            trigger_mode_bit_r <= 1'b0;
            irq_enable_r <= 1'b0;
        end else if (ctrl_write) begin
            conversion_enable_bit_r <= hwdata[adcss_pkg::BIT_ENABLE];
            select_channel_bit0_r <= hwdata[adcss_pkg::BIT_SEL0];
            select_channel_bit1_r <= hwdata[adcss_pkg::BIT_SEL1];
            input_mode_bit_r <= hwdata[adcss_pkg::BIT_MODE];
            trigger_mode_bit_r <= hwdata[adcss_pkg::BIT_TRIG];
            irq_enable_r <= hwdata[adcss_pkg::BIT_IRQEN];
        end
    end

    // software clear only.
    // A completion in the same cycle as a clearing write wins.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            conversion_done_flag_r <= 1'b0;
        end else if (cycle_end) begin
            conversion_done_flag_r <= 1'b1;
        end else if (done_clear) begin
            conversion_done_flag_r <= 1'b0;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            converter_irq <= 1'b0;
        end else begin
            converter_irq <= (conversion_done_flag_r || cycle_end) && irq_enable_r;
        end
    end

    // Read decode; unmapped offsets read as zero.
    always_comb begin
        rd_word = adcss_pkg::RST_WORD;
        if (rd_ofs == adcss_pkg::OFS_CONTROL) begin
            rd_word[adcss_pkg::BIT_DONE] = conversion_done_flag_r;
            rd_word[adcss_pkg::BIT_ENABLE] = conversion_enable_bit_r;
            rd_word[adcss_pkg::BIT_SEL0] = select_channel_bit0_r;
            rd_word[adcss_pkg::BIT_SEL1] = select_channel_bit1_r;
            rd_word[adcss_pkg::BIT_MODE] = input_mode_bit_r;
            rd_word[adcss_pkg::BIT_TRIG] = trigger_mode_bit_r;
            rd_word[adcss_pkg::BIT_IRQEN] = irq_enable_r;
            rd_word[adcss_pkg::BIT_BUSY] = sar_busy || (state_r == ADCSS_RUN);
        end else if (rd_ofs == adcss_pkg::OFS_THRESH) begin
            rd_word[7:0] = threshold_compare_result_r;
        end else if (rd_ofs >= adcss_pkg::OFS_RESULT0 && rd_ofs <= adcss_pkg::OFS_RESULT7
                     && rd_ofs[1:0] == 2'b00) begin
            rd_word[7:0] = result_r[3'(rd_ofs[7:2] - 6'h02)];
        end
    end

    // Read data is sampled in the address phase and stands in the data phase.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= adcss_pkg::RST_WORD;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            if (addr_valid && !hwrite) begin
                hrdata <= rd_word;
            end
        end
    end

endmodule : adcss_top

// file: verif/adcss_chk.sv
// Purpose: Concurrent checks on the port timing of the converter sequencer.
// Assumes: One clock domain, asynchronous active-low reset.
// Notes: A slot lasts 120 clocks (ten machine cycles), the sample window 12 clocks.
module adcss_chk (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic [2:0] mux_channel,
    input wire logic [7:0] ladder_code,
    input wire logic sample_hold,
    input wire logic converter_irq
);
    default clocking dcb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);
    logic [3:0] sh_cnt_r;
    logic [7:0] gap_r;
    logic [2:0] last_mux_r;
    logic [3:0] wr_ago_r;
    ////////////////////////////////////////////////////////////
    // Counts the clocks of the current sample window.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) sh_cnt_r <= 4'h0;
        else sh_cnt_r <= sample_hold ? sh_cnt_r + 4'h1 : 4'h0;
    end
    // Clocks since the last slot launch and the channel it used.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            gap_r <= 8'hFF;
            last_mux_r <= 3'h0;
        end else if (sample_hold && sh_cnt_r == 4'h0) begin // First clock of a window.
            gap_r <= 8'h00;
            last_mux_r <= mux_channel;
        end else if (gap_r != 8'hFF) gap_r <= gap_r + 8'h01;
    end
    // Clocks since a control write was taken on the bus.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) wr_ago_r <= 4'hF;
        else if (hsel && htrans[1] && hready && hwrite && haddr[7:0] == 8'h00) wr_ago_r <= 4'h0;
        else if (wr_ago_r != 4'hF) wr_ago_r <= wr_ago_r + 4'h1;
    end
    ////////////////////////////////////////////////////////////
    property p_next;
        logic [2:0] ch;
        ($rose(sample_hold) && mux_channel inside {3'h4, 3'h5, 3'h6}, ch = mux_channel)
        |-> ##120 ($rose(sample_hold) && mux_channel == ch + 3'h1);
    endproperty
    AST_READY: assert property (hreadyout)
        else $error("Slave inserted a wait state.");
    AST_OKAY: assert property (!hresp)
        else $error("Slave answered with an error response.");
    AST_SAR_START: assert property (sample_hold |-> ladder_code == 8'h80)
        else $error("Ladder not at mid scale while sampling.");
    AST_SH_WIDTH: assert property ($fell(sample_hold) |-> sh_cnt_r == 4'hC)
        else $error("Sample window is not one machine cycle.");
    AST_SLOT_NEXT: assert property (p_next)
        else $error("Upper slot not followed by next channel in 120 clocks.");
    AST_SLOT_MIN: assert property ($rose(sample_hold) |-> gap_r >= 8'h77)
        else $error("Slot launched less than 120 clocks after the last.");
    AST_MUX_HOLD: assert property (sample_hold && $past(sample_hold) |-> $stable(mux_channel))
        else $error("Input select moved during the sample window.");
    AST_DONE_LAST: assert property ($rose(converter_irq) |->
        last_mux_r == 3'h7 && gap_r >= 8'h64 && gap_r <= 8'h7D)
        else $error("Completion raised other than at the end of channel 7.");
    AST_IRQ_CLEAR: assert property ($fell(converter_irq) |-> wr_ago_r <= 4'h3)
        else $error("Completion dropped without a control write.");
    C_LAST: cover property ($rose(sample_hold) && mux_channel == 3'h7);
    C_IRQ: cover property ($rose(converter_irq));
    C_CLR: cover property ($fell(converter_irq));
endmodule : adcss_chk

bind adcss_top adcss_chk u_chk (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hready,
    .hreadyout, .hresp, .mux_channel, .ladder_code, .sample_hold, .converter_irq);

// file: verif/adcss_analog_model.sv
// Purpose: Analog inputs, comparators and trigger source facing the sequencer.
// Assumes: Level v stands for a voltage half a ladder step above code v.
// Notes: The trigger pin idles high, as with a pull-up.
module adcss_analog_model (
    input wire logic hclk,
    input wire logic [63:0] levels,
    input wire logic [7:0] thr_level,
    input wire logic [2:0] mux_channel,
    input wire logic [7:0] ladder_code,
    input wire logic sample_hold,
    output logic ladder_compare_in,
    output logic threshold_compare_in,
    output logic external_trigger_pin
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] held_r = 8'h00;
    ////////////////////////////////////////////////////////////
    // Hold capacitor tracks the selected input while sampling.
    always_ff @(posedge hclk) begin
        if (sample_hold) held_r <= levels[8*mux_channel+:8];
    end
    assign ladder_compare_in = (held_r >= ladder_code);
    assign threshold_compare_in = (held_r > thr_level);
    initial external_trigger_pin = 1'b1;
    task fire();
        external_trigger_pin <= 1'b0;
        repeat (24) @(posedge hclk);
        external_trigger_pin <= 1'b1;
        repeat (24) @(posedge hclk);
    endtask : fire
endmodule : adcss_analog_model

// file: verif/adc_scan_sequencer_tb.sv
// Purpose: Register-level test of the scan sequencer over AHB-Lite.
// Assumes: Zero wait state slave; 100 MHz clock.
// Notes: Expected codes come from the levels the bench applies.
module adc_scan_sequencer_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
    logic [1:0] htrans = 2'h0;
    logic hreadyout, hresp, external_trigger_pin, ladder_compare_in, threshold_compare_in;
    logic [2:0] mux_channel;
    logic [7:0] ladder_code, eth, thr_level = 8'h80;
    logic sample_hold, converter_irq;
    logic [63:0] levels = 64'h01C0_4081_7F80_FF00;
    logic [7:0] ev [8];
    logic [7:0] ro [4] = '{8'h04, 8'h08, 8'h24, 8'h28};
    int n_fail = 0, samples_checked = 0;
    always #5 hclk = ~hclk;
    adcss_top DUT (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
        .hready(hreadyout), .hrdata, .hreadyout, .hresp, .external_trigger_pin,
        .ladder_compare_in, .threshold_compare_in, .mux_channel, .ladder_code,
        .sample_hold, .converter_irq);
    adcss_analog_model M (.hclk, .levels, .thr_level, .mux_channel, .ladder_code,
        .sample_hold, .ladder_compare_in, .threshold_compare_in, .external_trigger_pin);
    ////////////////////////////////////////////////////////////
    task check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("[FAIL] %0t ns: saw %h, expected %h", $time, seen, exp);
        end
    endtask : check
    // One single transfer: address phase, then data phase.
    task bus(input logic [7:0] a, input logic wr, input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= wr;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask : bus
    function logic [31:0] ctl(input logic [1:0] s, input logic md, input logic irq);
        ctl = 32'h0;
        ctl[adcss_pkg::BIT_ENABLE] = 1'b1;
        ctl[adcss_pkg::BIT_SEL1:adcss_pkg::BIT_SEL0] = s;
        ctl[adcss_pkg::BIT_MODE] = md;
        ctl[adcss_pkg::BIT_TRIG] = md;
        ctl[adcss_pkg::BIT_IRQEN] = irq;
    endfunction : ctl
    task wait_done();
        do bus(adcss_pkg::OFS_CONTROL, 1'b0, 32'h0); while (rd[0] !== 1'b1);
    endtask : wait_done
    // Expected codes and threshold bits for one full cycle.
    task expect_cycle(input logic md, input logic [1:0] s);
        int src;
        for (int n = 0; n < 8; n++) begin
            src = (md && n < 4) ? int'(s) : n;
            ev[n] = levels[8*src+:8];
            eth[7-n] = ev[n] > thr_level;
        end
    endtask : expect_cycle
    task check_all();
        for (int n = 0; n < 8; n++) begin
            bus(adcss_pkg::OFS_RESULT0 + 8'(4*n), 1'b0, 32'h0);
            check(rd, {24'h0, ev[n]});
        end
        bus(adcss_pkg::OFS_THRESH, 1'b0, 32'h0);
        check(rd, {24'h0, eth});
    endtask : check_all
    task print_verdict();
        $display("Comparisons %0d, mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : print_verdict
    ////////////////////////////////////////////////////////////
    // Watchdog against a hung handshake or a missing completion.
    initial begin
        repeat (40000) @(posedge hclk);
        n_fail++;
        print_verdict();
    end
    // Main sequence: reset state, internal scan, external select.
    initial begin
        repeat (16) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        foreach (ro[i]) bus(ro[i], 1'b1, 32'hFFFF_FFFF);
        for (int a = 0; a < 12; a++) begin
            bus(8'(4*a), 1'b0, 32'h0);
            check(rd, adcss_pkg::RST_WORD);
        end
        bus(adcss_pkg::OFS_CONTROL, 1'b1, ctl(2'h0, 1'b0, 1'b1));
        wait_done();
        check(32'(converter_irq), 32'h1);
        expect_cycle(1'b0, 2'h0);
        check_all();
        levels = ~levels;
        repeat (2) begin
            bus(adcss_pkg::OFS_CONTROL, 1'b1, ctl(2'h0, 1'b0, 1'b1));
            repeat (2) @(posedge hclk);
            check(32'(converter_irq), 32'h0);
            wait_done();
        end
        expect_cycle(1'b0, 2'h0);
        check_all();
        repeat (300) @(posedge hclk);
        bus(adcss_pkg::OFS_CONTROL, 1'b0, 32'h0);
        check(rd & 32'h1, 32'h1);
        bus(adcss_pkg::OFS_CONTROL, 1'b1, 32'h0);
        levels = 64'h0;
        repeat (1200) @(posedge hclk);
        check_all();
        for (int s = 0; s < 4; s++) begin
            levels = {8{8'(8'h30 * s + 8'h17)}} ^ 64'h0F1E_2D3C_4B5A_6978;
            bus(adcss_pkg::OFS_CONTROL, 1'b1, ctl(2'(s), 1'b1, 1'b0));
            repeat (200) @(posedge hclk);
            bus(adcss_pkg::OFS_CONTROL, 1'b0, 32'h0);
            check(rd, ctl(2'(s), 1'b1, 1'b0));
            M.fire();
            repeat (300) @(posedge hclk);
            M.fire();
            wait_done();
            check(32'(converter_irq), 32'h0);
            expect_cycle(1'b1, 2'(s));
            check_all();
            bus(adcss_pkg::OFS_CONTROL, 1'b1, ctl(2'(s), 1'b1, 1'b0));
            repeat (1200) @(posedge hclk);
            bus(adcss_pkg::OFS_CONTROL, 1'b0, 32'h0);
            check(rd, ctl(2'(s), 1'b1, 1'b0));
        end
        print_verdict();
    end
endmodule : adc_scan_sequencer_tb
